// *** rtl/serial_bus_pkg.sv ***
// Shared constants for the serial bus unit and its bus partner.
// Assumes one 250 MHz system clock and a wired-AND two-wire bus.
// How it works
// - Own or general-call address sets match flag
// - Recognition off: first word sets match flag
// - Data buffer access clears match flag
// - Recognition on: all-zero first byte to a slave sets general-call flag
// - Start or stop clears general-call flag
// - Last bit samples data at clock rise
// - Last bit after interrupt holds acknowledge
// - Buffer read consumes, write supplies, address starts
// - Idle select decides running during idle
// - Reset field 10 then 01 resets unit
// - Soft reset restores registers; field reads back as ad0 and last_rx_bit
// - Soft reset returns mode to port mode
// - Slave setup: pins high, then control write
// - Bus free: 1111 write makes start
// - Nine clocks: eight address, ninth acknowledge
// - Ninth fall: interrupt, clear pending, hold clock
// - Master direction update only when acknowledged
// - Matched slave drives acknowledge low
// - Transmitter: one means stop, zero continue
// - Transmit write sets pending, clocks next word
// - Word done: interrupt, clear pending, hold clock
// - Check bus free before writing address
// - Pending set by access or one; zero ignored
package serial_bus_pkg;
    // Register offsets; status shares the offset of control two
    localparam logic [7:0] CR1_OFS   = 8'h00;
    localparam logic [7:0] DBR_OFS   = 8'h04;
    localparam logic [7:0] CAR_OFS   = 8'h08;
    localparam logic [7:0] CR2_OFS   = 8'h0C;
    localparam logic [7:0] BR0_OFS   = 8'h10;

    localparam int BYTE_MSB  = 7;
    localparam int BC_HI     = 7;
    localparam int BC_LO     = 5;
    localparam int ACK_BIT   = 4;
    localparam int SCK_HI    = 2;
    localparam int SCK_LO    = 0;
    localparam int MST_BIT   = 7;
    localparam int TRX_BIT   = 6;
    localparam int BB_BIT    = 5;
    localparam int PIN_BIT   = 4;
    localparam int SBIM_HI   = 3;
    localparam int SBIM_LO   = 2;
    localparam int SWRST_HI  = 1;
    localparam int SWRST_LO  = 0;
    localparam int ADDR_HI   = 7;
    localparam int ADDR_LO   = 1;
    localparam int ALS_BIT   = 0;
    localparam int DIR_BIT   = 0;
    localparam int IDLE_BIT  = 6;

    localparam logic [1:0] SWRST_FIRST  = 2'h2;
    localparam logic [1:0] SWRST_SECOND = 2'h1;
    localparam logic [1:0] MODE_I2C     = 2'h2;
    localparam logic [1:0] MODE_PORT    = 2'h0;
    localparam logic [3:0] START_CMD    = 4'hF;
    localparam logic [2:0] BC_FULL      = 3'h0;
    localparam logic [3:0] WORD_BITS    = 4'h8;
    localparam logic [3:0] ACK_POS      = 4'h8;
    localparam logic [3:0] END_POS      = 4'h9;
    localparam logic [7:0] GENERAL_CALL = 8'h00;
    localparam logic       PIN_RST      = 1'h1;

    // Half period of the generated clock for divider setting zero
    localparam int SCL_HALF_BASE_NS = 64;
    localparam int CLK_PERIOD_NS    = 4;
    localparam logic [15:0] SCL_HALF_BASE_CYC =
        16'((SCL_HALF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_LOW, M_STOP_HIGH
    } master_state_e;

    typedef struct packed {
        logic [2:0] bc;
        logic       ack;
        logic [2:0] sck;
        logic [6:0] own_addr;
        logic       addr_recog_disable;
        logic       idle_run;
        logic [1:0] sbim;
        logic       arm;
        logic       mst;
        logic       trx;
        logic       bb;
        logic       pin;
        logic       al;
        logic       addr_matched_flag;
        logic       ad0;
        logic       last_rx_bit;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic       addr_phase;
        logic       addressed;
        logic       data_low;
        logic       irq;
        logic       stop_req;
    } unit_state_s;

    localparam unit_state_s UNIT_RST = '{pin: PIN_RST, sbim: MODE_PORT, default: '0};
endpackage : serial_bus_pkg

// *** rtl/serial_bus_if.sv ***
// Two-wire bus joining the unit and its partner.
// Each end gives output, output enable; the line is the wired-AND.
`timescale 1ns/1ps
`default_nettype none
interface serial_bus_if;
    logic scl_dev_o;
    logic scl_dev_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl_far_o;
    logic scl_far_oe;
    logic sda_far_o;
    logic sda_far_oe;
    logic scl_line;
    logic sda_line;

    assign scl_line = ~((scl_dev_oe & ~scl_dev_o) | (scl_far_oe & ~scl_far_o));
    assign sda_line = ~((sda_dev_oe & ~sda_dev_o) | (sda_far_oe & ~sda_far_o));

    modport dev (output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe,
                 input scl_line, sda_line);
    modport far (output scl_far_o, scl_far_oe, sda_far_o, sda_far_oe,
                 input scl_line, sda_line);
endinterface : serial_bus_if
`default_nettype wire

// *** rtl/serial_bus_unit.sv ***
// Serial bus unit: register port on one side, two-wire bus on the other.
// Register port and bus pins are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module serial_bus_unit (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       idle_mode,
    output logic            bus_irq,
    output logic            port_mode,
    serial_bus_if.dev       bus
);
    serial_bus_pkg::unit_state_s   s;
    serial_bus_pkg::unit_state_s   n;
    serial_bus_pkg::master_state_e ms_ff;
    serial_bus_pkg::master_state_e nxt_ms;
    logic [15:0] div_ff;
    logic [15:0] nxt_div;
    logic        scl_d_ff;
    logic        sda_d_ff;
    logic [7:0]  rdata_ff;

    // Register decode
    wire wr_cr1     = reg_wr & (reg_addr == serial_bus_pkg::CR1_OFS);
    wire wr_dbr     = reg_wr & (reg_addr == serial_bus_pkg::DBR_OFS);
    wire rd_dbr     = reg_rd & (reg_addr == serial_bus_pkg::DBR_OFS);
    wire wr_car     = reg_wr & (reg_addr == serial_bus_pkg::CAR_OFS);
    wire wr_cr2     = reg_wr & (reg_addr == serial_bus_pkg::CR2_OFS);
    wire wr_br0     = reg_wr & (reg_addr == serial_bus_pkg::BR0_OFS);
    wire dbr_access = wr_dbr | rd_dbr;
    wire [1:0] sw_field = reg_wdata[serial_bus_pkg::SWRST_HI:serial_bus_pkg::SWRST_LO];

    wire soft_rst = wr_cr2 & s.arm & (sw_field == serial_bus_pkg::SWRST_SECOND);

    // Mode and idle gating
    wire i2c_on = (s.sbim == serial_bus_pkg::MODE_I2C);
    wire frozen = idle_mode & ~s.idle_run;
    wire active = i2c_on & ~frozen;

    wire start_cmd = active & wr_cr2 & ~s.bb &
        (reg_wdata[serial_bus_pkg::MST_BIT:serial_bus_pkg::PIN_BIT]
         == serial_bus_pkg::START_CMD);
    wire stop_cmd = active & wr_cr2 & s.bb & s.mst & reg_wdata[serial_bus_pkg::MST_BIT] &
        reg_wdata[serial_bus_pkg::TRX_BIT] & reg_wdata[serial_bus_pkg::PIN_BIT] &
        ~reg_wdata[serial_bus_pkg::BB_BIT];

    // Bus event detection
    wire sda_in   = bus.sda_line;
    wire ev_start = active & scl_d_ff & bus.scl_line & sda_d_ff & ~sda_in;
    wire ev_stop  = active & scl_d_ff & bus.scl_line & ~sda_d_ff & sda_in;
    wire listen   = s.bb & s.pin & (s.mst | s.addressed | s.addr_phase);
    wire ev_rise  = active & listen & ~scl_d_ff & bus.scl_line;
    wire ev_fall  = active & listen & scl_d_ff & ~bus.scl_line;

    // Word shape: address words are always eight bits, plus acknowledge when recognition is on or ack is set
    wire [3:0] data_bits = (s.bc == serial_bus_pkg::BC_FULL) ?
                           serial_bus_pkg::WORD_BITS : {1'h0, s.bc};
    wire [3:0] nbits  = s.addr_phase ? serial_bus_pkg::WORD_BITS : data_bits;
    wire       ack_en = (s.addr_phase & ~s.addr_recog_disable) | s.ack;
    wire [3:0] total  = 4'(nbits + {3'h0, ack_en});
    wire       in_data = (s.bitcnt < nbits);

    wire gen_call   = (s.shift == serial_bus_pkg::GENERAL_CALL);
    wire addr_match = (s.shift[serial_bus_pkg::ADDR_HI:serial_bus_pkg::ADDR_LO]
                       == s.own_addr) | gen_call;
    wire ack_drive  = s.addr_phase ?
                      (~s.mst & (s.addr_recog_disable ? (s.ack & ~s.trx) : addr_match)) :
                      (s.ack & ~s.trx);
    // Stop sequence pulls SDA low under a rising clock on purpose
    wire lost = s.mst & s.trx & ~s.stop_req & in_data & ~s.data_low & ~sda_in;

    always_comb begin
        n = s;
        n.irq = 1'h0;
        if (wr_cr1) begin
            n.bc  = reg_wdata[serial_bus_pkg::BC_HI:serial_bus_pkg::BC_LO];
            n.ack = reg_wdata[serial_bus_pkg::ACK_BIT];
            n.sck = reg_wdata[serial_bus_pkg::SCK_HI:serial_bus_pkg::SCK_LO];
        end
        if (wr_car) begin
            n.own_addr = reg_wdata[serial_bus_pkg::ADDR_HI:serial_bus_pkg::ADDR_LO];
            n.addr_recog_disable      = reg_wdata[serial_bus_pkg::ALS_BIT];
        end
        if (wr_br0) begin
            n.idle_run = reg_wdata[serial_bus_pkg::IDLE_BIT];
        end
        if (wr_cr2) begin
            n.sbim = reg_wdata[serial_bus_pkg::SBIM_HI:serial_bus_pkg::SBIM_LO];
            n.arm  = (sw_field == serial_bus_pkg::SWRST_FIRST);
            n.mst  = reg_wdata[serial_bus_pkg::MST_BIT];
            n.trx  = reg_wdata[serial_bus_pkg::TRX_BIT];
            n.al   = 1'h0;
        end
        if (dbr_access) begin
            n.addr_matched_flag = 1'h0;
            n.al  = 1'h0;
        end
        if (wr_dbr) begin
            n.shift = reg_wdata;
            // Only mid-transfer: an idle bus must never see SDA pulled
            if (s.bb & ~s.addr_phase) begin
                n.data_low = s.trx & ~reg_wdata[serial_bus_pkg::BYTE_MSB];
            end
        end
        if (stop_cmd) begin
            n.stop_req = 1'h1;
        end
        if (ev_start) begin
            n.bb         = 1'h1;
            n.ad0        = 1'h0;
            n.addr_phase = 1'h1;
            n.addressed  = 1'h0;
            n.bitcnt     = 4'h0;
        end
        if (ev_stop) begin
            n.bb         = 1'h0;
            n.ad0        = 1'h0;
            n.mst        = 1'h0;
            n.trx        = 1'h0;
            n.addr_phase = 1'h0;
            n.addressed  = 1'h0;
            n.data_low   = 1'h0;
            n.bitcnt     = 4'h0;
            n.stop_req   = 1'h0;
        end
        if (ev_rise) begin
            n.last_rx_bit    = sda_in;
            n.bitcnt = 4'(s.bitcnt + 4'h1);
            if (in_data) begin
                n.shift = {s.shift[serial_bus_pkg::BYTE_MSB-1:0], sda_in};
            end
            if (lost) begin
                n.al       = 1'h1;
                n.mst      = 1'h0;
                n.trx      = 1'h0;
                n.data_low = 1'h0;
            end
        end
        if (ev_fall) begin
            if (s.bitcnt == total) begin
                n.irq      = 1'h1;
                n.pin      = 1'h0;
                n.data_low = 1'h0;
                n.bitcnt   = 4'h0;
                if (s.addr_phase) begin
                    n.addr_phase = 1'h0;
                    if (s.mst) begin
                        if (~s.last_rx_bit) begin
                            n.trx = ~s.shift[serial_bus_pkg::DIR_BIT];
                        end
                    end else if (s.addr_recog_disable | addr_match) begin
                        n.addr_matched_flag       = 1'h1;
                        n.addressed = 1'h1;
                        n.ad0       = gen_call & ~s.addr_recog_disable;
                        if (~s.addr_recog_disable) begin
                            n.trx = s.shift[serial_bus_pkg::DIR_BIT];
                        end
                    end else begin
                        // Not for us: stay quiet until the next start
                        n.irq = 1'h0;
                        n.pin = s.pin;
                    end
                end
            end else if (in_data) begin
                n.data_low = s.trx & ~s.shift[serial_bus_pkg::BYTE_MSB];
            end else begin
                n.data_low = ack_drive;
            end
        end
        // Software set wins over a same-cycle hardware clear
        if (dbr_access | (wr_cr2 & reg_wdata[serial_bus_pkg::PIN_BIT])) begin
            n.pin = 1'h1;
        end
        if (soft_rst) begin
            n = serial_bus_pkg::UNIT_RST;
        end
    end

    // Master clock generator
    wire [15:0] half_cyc = serial_bus_pkg::SCL_HALF_BASE_CYC << s.sck;
    wire        div_tick = (div_ff >= half_cyc);
    wire        div_run  = ((ms_ff != serial_bus_pkg::M_HIGH) &&
                            (ms_ff != serial_bus_pkg::M_STOP_HIGH)) || bus.scl_line;

    always_comb begin
        nxt_ms  = ms_ff;
        nxt_div = (div_tick || !div_run) ? div_ff : 16'(div_ff + 16'h0001);
        unique case (ms_ff)
            serial_bus_pkg::M_IDLE: begin
                if (start_cmd) nxt_ms = serial_bus_pkg::M_START;
            end
            serial_bus_pkg::M_START: begin
                if (div_tick) nxt_ms = serial_bus_pkg::M_LOW;
            end
            serial_bus_pkg::M_LOW: begin
                if (!s.mst) nxt_ms = serial_bus_pkg::M_IDLE;
                else if (div_tick && s.stop_req) nxt_ms = serial_bus_pkg::M_STOP_LOW;
                else if (div_tick && s.pin) nxt_ms = serial_bus_pkg::M_HIGH;
            end
            serial_bus_pkg::M_HIGH: begin
                if (!s.mst) nxt_ms = serial_bus_pkg::M_IDLE;
                else if (div_tick) nxt_ms = serial_bus_pkg::M_LOW;
            end
            serial_bus_pkg::M_STOP_LOW: begin
                if (div_tick) nxt_ms = serial_bus_pkg::M_STOP_HIGH;
            end
            serial_bus_pkg::M_STOP_HIGH: begin
                if (div_tick) nxt_ms = serial_bus_pkg::M_IDLE;
            end
        endcase
        if (nxt_ms != ms_ff) nxt_div = 16'h0000;
        if (frozen) begin
            nxt_ms  = ms_ff;
            nxt_div = div_ff;
        end
        if (soft_rst || !i2c_on) begin
            nxt_ms  = serial_bus_pkg::M_IDLE;
            nxt_div = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s        <= serial_bus_pkg::UNIT_RST;
            ms_ff    <= serial_bus_pkg::M_IDLE;
            div_ff   <= 16'h0000;
            scl_d_ff <= 1'h1;
            sda_d_ff <= 1'h1;
        end else begin
            s        <= n;
            ms_ff    <= nxt_ms;
            div_ff   <= nxt_div;
            scl_d_ff <= bus.scl_line;
            sda_d_ff <= bus.sda_line;
        end
    end

    // Register read; reset field never stored, its bits read back as status ad0 and last_rx_bit
    wire [7:0] cr1_view = {s.bc, s.ack, 1'h0, s.sck};
    wire [7:0] sr_view  = {s.mst, s.trx, s.bb, s.pin, s.al, s.addr_matched_flag, s.ad0, s.last_rx_bit};
    wire [7:0] car_view = {s.own_addr, s.addr_recog_disable};
    wire [7:0] br0_view = 8'(s.idle_run) << serial_bus_pkg::IDLE_BIT;
    wire [7:0] rd_mux =
        (reg_addr == serial_bus_pkg::CR1_OFS) ? cr1_view :
        (reg_addr == serial_bus_pkg::DBR_OFS) ? s.shift  :
        (reg_addr == serial_bus_pkg::CAR_OFS) ? car_view :
        (reg_addr == serial_bus_pkg::CR2_OFS) ? sr_view  :
        (reg_addr == serial_bus_pkg::BR0_OFS) ? br0_view : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rdata_ff <= 8'h00;
        else if (reg_rd) rdata_ff <= rd_mux;
    end

    wire m_scl_low = (ms_ff == serial_bus_pkg::M_LOW) || (ms_ff == serial_bus_pkg::M_STOP_LOW);
    wire m_sda_low = (ms_ff == serial_bus_pkg::M_START) ||
                     (ms_ff == serial_bus_pkg::M_STOP_LOW) ||
                     (ms_ff == serial_bus_pkg::M_STOP_HIGH);

    assign reg_rdata      = rdata_ff;
    assign bus_irq        = s.irq;
    assign port_mode      = ~i2c_on;
    assign bus.scl_dev_o  = 1'h0;
    assign bus.sda_dev_o  = 1'h0;
    assign bus.scl_dev_oe = i2c_on & (m_scl_low | (s.addressed & s.bb & ~s.pin));
    assign bus.sda_dev_oe = i2c_on & (s.data_low | m_sda_low);
endmodule : serial_bus_unit
`default_nettype wire

// *** rtl/i2c_far_end.sv ***
// Bus partner: a plain slave that answers one address.
// Bus pins synchronous to sys_clk; every word has an acknowledge clock.
`timescale 1ns/1ps
`default_nettype none
module i2c_far_end (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [6:0] slave_addr,
    input  wire logic [7:0] tx_byte,
    input  wire logic       nack_next,
    input  wire logic       hold_scl,
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    output logic            addr_hit,
    serial_bus_if.far       bus
);
    logic       scl_d_ff;
    logic       sda_d_ff;
    logic [3:0] pos_ff;
    logic [7:0] shift_ff;
    logic [7:0] txsh_ff;
    logic       addr_phase_ff;
    logic       active_ff;
    logic       dir_ff;
    logic       sda_low_ff;
    logic       mnack_ff;
    logic       hold_ff;
    logic [7:0] rx_byte_ff;
    logic       rx_valid_ff;
    logic       addr_hit_ff;

    wire ev_start = scl_d_ff & bus.scl_line & sda_d_ff & ~bus.sda_line;
    wire ev_stop  = scl_d_ff & bus.scl_line & ~sda_d_ff & bus.sda_line;
    wire listen   = addr_phase_ff | active_ff;
    wire ev_rise  = listen & ~scl_d_ff & bus.scl_line;
    wire ev_fall  = listen & scl_d_ff & ~bus.scl_line;
    wire match    = (shift_ff[serial_bus_pkg::ADDR_HI:serial_bus_pkg::ADDR_LO] == slave_addr);
    wire in_data  = (pos_ff < serial_bus_pkg::WORD_BITS);
    wire [7:0] tx_rest = {tx_byte[serial_bus_pkg::BYTE_MSB-1:0], 1'h0};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_ff <= 1'h1;
            sda_d_ff <= 1'h1;
            pos_ff <= 4'h0;
            shift_ff <= 8'h00;
            txsh_ff <= 8'h00;
            addr_phase_ff <= 1'h0;
            active_ff <= 1'h0;
            dir_ff <= 1'h0;
            sda_low_ff <= 1'h0;
            mnack_ff <= 1'h0;
            hold_ff <= 1'h0;
            rx_byte_ff <= 8'h00;
            rx_valid_ff <= 1'h0;
            addr_hit_ff <= 1'h0;
        end else begin
            scl_d_ff <= bus.scl_line;
            sda_d_ff <= bus.sda_line;
            rx_valid_ff <= 1'h0;
            addr_hit_ff <= 1'h0;
            // Stretch only from a low clock so a high phase is never cut
            hold_ff <= hold_scl & active_ff & (hold_ff | ~bus.scl_line);
            if (ev_start) begin
                pos_ff <= 4'h0;
                addr_phase_ff <= 1'h1;
                active_ff <= 1'h0;
                sda_low_ff <= 1'h0;
            end else if (ev_stop) begin
                addr_phase_ff <= 1'h0;
                active_ff <= 1'h0;
                sda_low_ff <= 1'h0;
            end else if (ev_rise) begin
                pos_ff <= 4'(pos_ff + 4'h1);
                if (in_data) shift_ff <= {shift_ff[serial_bus_pkg::BYTE_MSB-1:0], bus.sda_line};
                else mnack_ff <= bus.sda_line;
            end else if (ev_fall) begin
                if (pos_ff == serial_bus_pkg::ACK_POS) begin
                    if (addr_phase_ff) sda_low_ff <= match;
                    else sda_low_ff <= ~dir_ff & ~nack_next;
                end else if (pos_ff == serial_bus_pkg::END_POS) begin
                    pos_ff <= 4'h0;
                    sda_low_ff <= 1'h0;
                    if (addr_phase_ff) begin
                        addr_phase_ff <= 1'h0;
                        active_ff <= match;
                        dir_ff <= shift_ff[serial_bus_pkg::DIR_BIT];
                        addr_hit_ff <= match;
                        if (match & shift_ff[serial_bus_pkg::DIR_BIT]) begin
                            txsh_ff <= tx_rest;
                            sda_low_ff <= ~tx_byte[serial_bus_pkg::BYTE_MSB];
                        end
                    end else if (dir_ff) begin
                        // Master answering one wants no more data
                        if (mnack_ff) begin
                            active_ff <= 1'h0;
                        end else begin
                            txsh_ff <= tx_rest;
                            sda_low_ff <= ~tx_byte[serial_bus_pkg::BYTE_MSB];
                        end
                    end else begin
                        rx_byte_ff <= shift_ff;
                        rx_valid_ff <= 1'h1;
                    end
                end else if (active_ff & dir_ff) begin
                    sda_low_ff <= ~txsh_ff[serial_bus_pkg::BYTE_MSB];
                    txsh_ff <= {txsh_ff[serial_bus_pkg::BYTE_MSB-1:0], 1'h0};
                end
            end
        end
    end

    assign rx_byte        = rx_byte_ff;
    assign rx_valid       = rx_valid_ff;
    assign addr_hit       = addr_hit_ff;
    assign bus.scl_far_o  = 1'h0;
    assign bus.sda_far_o  = 1'h0;
    assign bus.scl_far_oe = hold_ff;
    assign bus.sda_far_oe = sda_low_ff;
endmodule : i2c_far_end
`default_nettype wire

// *** sim/serial_bus_checker.sv ***
// Wire checks on the two-wire bus joining the unit and the far end.
// Assumes both ends on sys_clk, sck=0 and eight-bit words with ack.
`timescale 1ns/1ps
`default_nettype none
module serial_bus_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_line,
    input wire logic sda_line,
    input wire logic sda_dev_oe,
    input wire logic sda_far_oe
);
    logic       scl_q_ff;
    logic       sda_q_ff;
    logic [7:0] rise_ff;
    logic [7:0] low_ff;
    wire        start_w = scl_q_ff & scl_line & sda_q_ff & ~sda_line;

    // Clock rises since the last start; held-low length saturates
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            rise_ff  <= 8'h00;
            low_ff   <= 8'h00;
        end else begin
            scl_q_ff <= scl_line;
            sda_q_ff <= sda_line;
            rise_ff  <= start_w ? 8'h00 : rise_ff + {7'h00, scl_line & ~scl_q_ff};
            low_ff   <= scl_line ? 8'h00 : low_ff + {7'h00, low_ff != 8'hFF};
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_low_phase: assert property ($fell(scl_line) |-> !scl_line[*8])
        else $error("clock low phase too short");
    chk_high_phase: assert property ($rose(scl_line) |-> scl_line[*8])
        else $error("clock high phase too short");
    chk_start_clock: assert property (start_w |-> ##[1:40] !scl_line)
        else $error("no clock after start");
    chk_stop_idle: assert property ($rose(sda_line) && scl_line && $past(scl_line)
        |-> ##1 scl_line[*8]) else $error("clock moved after stop");
    chk_nine_clocks: assert property (low_ff == 8'd40 |-> rise_ff != 8'd0
        && rise_ff % 9 == 0) else $error("clock held at wrong count");
    chk_far_ack_slot: assert property ($rose(sda_far_oe) |-> rise_ff % 9 == 8)
        else $error("far end pulled data outside ack slot");
    chk_ninth_release: assert property ($rose(scl_line) && rise_ff % 9 == 8
        |-> !sda_dev_oe) else $error("unit drove data in ninth clock");
    chk_far_low_move: assert property ($changed(sda_far_oe) |-> !scl_line)
        else $error("far end moved data while clock high");
endmodule : serial_bus_checker
`default_nettype wire

// *** sim/i2c_bus_status_and_transfer_test.sv ***
// Bench: the unit as master writes words to the far end slave.
// Assumes sck=0, eight-bit words with ack; idle mode entered once, with the unit frozen.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_status_and_transfer_test;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       bus_irq;
    logic       port_mode;
    logic       nack_next = 1'b0;
    logic       idle_mode = 1'b0;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       addr_hit;
    logic [7:0] got_rx = 8'h00;
    int         hits = 0;
    int         failures = 0;
    int         samples_checked = 0;
    serial_bus_if bus_if ();
    serial_bus_unit u_serial_bus_unit (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .idle_mode(idle_mode), .bus_irq(bus_irq), .port_mode(port_mode), .bus(bus_if.dev));
    i2c_far_end u_i2c_far_end (.sys_clk(sys_clk), .rst_n(rst_n), .slave_addr(7'h2A),
        .tx_byte(8'h00), .nack_next(nack_next), .hold_scl(1'b0), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .addr_hit(addr_hit), .bus(bus_if.far));
    serial_bus_checker u_serial_bus_checker (.sys_clk(sys_clk), .rst_n(rst_n),
        .scl_line(bus_if.scl_line), .sda_line(bus_if.sda_line),
        .sda_dev_oe(bus_if.sda_dev_oe), .sda_far_oe(bus_if.sda_far_oe));
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (rx_valid) got_rx <= rx_byte;
        if (addr_hit) hits <= hits + 1;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask : rd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // Pause after the pulse so the held clock is long enough to observe
    task automatic wait_irq();
        int n;
        n = 0;
        while (bus_irq !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 3000) begin
            failures++;
            complete_run();
        end
        repeat (50) @(negedge sys_clk);
    endtask : wait_irq
    task automatic stop_bus(output logic [7:0] v);
        int n;
        n = 0;
        wr(8'h0C, 8'hD8);
        do begin
            rd(8'h0C, v);
            n++;
        end while (v[5] !== 1'b0 && n < 100);
        if (v[5] !== 1'b0) begin
            failures++;
            complete_run();
        end
    endtask : stop_bus
    task automatic test_reset();
        logic [7:0] v;
        rd(8'h0C, v);
        check(v, 8'h10);
        check({7'h00, port_mode}, 8'h01);
        $display("reset values done");
    endtask : test_reset
    task automatic test_soft_reset();
        logic [7:0] v;
        wr(8'h0C, 8'h18);
        check({7'h00, port_mode}, 8'h00);
        wr(8'h0C, 8'h19);
        check({7'h00, port_mode}, 8'h00);
        wr(8'h0C, 8'h1A);
        wr(8'h00, 8'h10);
        wr(8'h0C, 8'h19);
        check({7'h00, port_mode}, 8'h01);
        rd(8'h00, v);
        check(v, 8'h00);
        rd(8'h0C, v);
        check(v, 8'h10);
        $display("soft reset done");
    endtask : test_soft_reset
    task automatic test_master_write();
        logic [7:0] v;
        wr(8'h00, 8'h10);
        wr(8'h0C, 8'h18);
        idle_mode = 1'b1;
        wr(8'h04, 8'h54);
        wr(8'h0C, 8'hF8);
        repeat (40) @(negedge sys_clk);
        rd(8'h0C, v);
        check(v, 8'hD0);
        idle_mode = 1'b0;
        wr(8'h0C, 8'h18);
        rd(8'h0C, v);
        check(v, 8'h10);
        wr(8'h0C, 8'hF8);
        wait_irq();
        rd(8'h0C, v);
        check(v, 8'hE0);
        check(8'(hits), 8'h01);
        wr(8'h04, 8'hA5);
        wait_irq();
        rd(8'h0C, v);
        check(v, 8'hE0);
        check(got_rx, 8'hA5);
        nack_next = 1'b1;
        wr(8'h04, 8'h3C);
        wait_irq();
        nack_next = 1'b0;
        rd(8'h0C, v);
        check(v, 8'hE1);
        stop_bus(v);
        check(v, 8'h10);
        $display("master write done");
    endtask : test_master_write
    task automatic test_addr_nack();
        logic [7:0] v;
        wr(8'h04, 8'h57);
        wr(8'h0C, 8'hF8);
        wait_irq();
        rd(8'h0C, v);
        check(v, 8'hE1);
        stop_bus(v);
        check(v, 8'h10);
        $display("address nack done");
    endtask : test_addr_nack
    initial begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        test_reset();
        test_soft_reset();
        test_master_write();
        test_addr_nack();
        complete_run();
    end
endmodule : i2c_bus_status_and_transfer_test
`default_nettype wire
